// ### pkg/blm_regs.svh
// register offsets, field positions, reset values and timing counts of the backlight control
`ifndef BLM_REGS_SVH
`define BLM_REGS_SVH
`define BLM_ENABLE_OFFSET 8'h10
`define BLM_CHIP_EN_BIT 0
`define BLM_STRING_EN_LSB 1
`define BLM_MAPPING_OFFSET 8'h11
`define BLM_MAPPING_BIT 7
`define BLM_MODE_OFFSET 8'h19
`define BLM_MODE_LSB 5
`define BLM_RST_CHIP_EN 1'h1
`define BLM_RST_STRING_EN 3'h7
`define BLM_RST_MODE 2'h1
`define BLM_RST_MAPPING 1'h0
`define BLM_RST_BRIGHTNESS 11'h000
`define BLM_PWM_PERIOD_CYCLES 12'hFFF
`define BLM_RAMP_STEP 11'h001
`endif

// ### pkg/blm_pkg.sv
// types shared by the backlight enable and mode control
package blm_pkg;
   typedef enum logic [1:0] {
      BLM_SRC_I2C = 2'h0,
      BLM_SRC_PWM = 2'h1,
      BLM_SRC_PROD_A = 2'h2,
      BLM_SRC_PROD_B = 2'h3
   } blm_src_t;
   typedef enum logic [2:0] {
      BLM_ST_SHUTDOWN = 3'h1,
      BLM_ST_STANDBY = 3'h2,
      BLM_ST_ACTIVE = 3'h4
   } blm_state_t;
   // configuration bits the host has written
   typedef struct packed {
      logic chip_en;
      logic [2:0] string_en;
      blm_src_t mode;
      logic exp_map;
      logic [10:0] brightness;
   } blm_cfg_t;
   // commands to the analogue current stage
   typedef struct packed {
      logic current_on;
      logic [2:0] sink_on;
      logic exp_map;
      logic [10:0] code;
   } blm_drive_t;
endpackage : blm_pkg

// ### core/blm_control.sv
// enable, standby and brightness-source control of the three-string backlight driver
`timescale 1ns/1ps
`include "blm_regs.svh"
module blm_control #(
   parameter int PWM_PERIOD = 4095
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic hardware_master_enable_pin,
   input wire logic pwm_in,
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [2:0] wr_bright_hi,
   output blm_pkg::blm_cfg_t cfg,
   output blm_pkg::blm_drive_t drive,
   output blm_pkg::blm_state_t state
);
   initial begin
      if (PWM_PERIOD < 2 || PWM_PERIOD > 4095) begin
         $error("PWM_PERIOD out of range");
      end
   end
   logic [2:0] en_sync;
   logic [2:0] pwm_sync;
   logic en_lvl;
   logic pwm_lvl;
   logic [11:0] period_cnt;
   logic [11:0] high_cnt;
   logic [10:0] pwm_code;
   logic [10:0] target;
   logic [10:0] ramp;
   logic [21:0] product;
   logic next_on;
   blm_pkg::blm_state_t next_state;
   logic rst_all;
   // pin inputs: three flops, a change counts when the last two agree
   always_ff @(posedge clock) begin
      if (srst) begin
         en_sync <= 3'h0;
         pwm_sync <= 3'h0;
      end else begin
         en_sync <= {en_sync[1:0], hardware_master_enable_pin};
         pwm_sync <= {pwm_sync[1:0], pwm_in};
      end
   end
   always_ff @(posedge clock) begin
      if (srst) begin
         en_lvl <= 1'h0;
         pwm_lvl <= 1'h0;
      end else begin
         if (en_sync[2] == en_sync[1]) begin
            en_lvl <= en_sync[2];
         end
         if (pwm_sync[2] == pwm_sync[1]) begin
            pwm_lvl <= pwm_sync[2];
         end
      end
   end
   // enable pin low resets the configuration, duty measurement and ramp registers
   assign rst_all = srst || !en_lvl;
   // register writes, only while enabled; values kept in standby
   always_ff @(posedge clock) begin
      if (rst_all) begin
         cfg.chip_en <= `BLM_RST_CHIP_EN;
         cfg.string_en <= `BLM_RST_STRING_EN;
         cfg.mode <= blm_pkg::blm_src_t'(`BLM_RST_MODE);
         cfg.exp_map <= `BLM_RST_MAPPING;
         cfg.brightness <= `BLM_RST_BRIGHTNESS;
      end else if (wr_en) begin
         unique case (wr_addr)
            `BLM_ENABLE_OFFSET: begin
               cfg.chip_en <= wr_data[`BLM_CHIP_EN_BIT];
               cfg.string_en <= wr_data[`BLM_STRING_EN_LSB +: 3];
            end
            `BLM_MAPPING_OFFSET: begin
               cfg.exp_map <= wr_data[`BLM_MAPPING_BIT];
            end
            `BLM_MODE_OFFSET: begin
               cfg.mode <= blm_pkg::blm_src_t'(wr_data[`BLM_MODE_LSB +: 2]);
               cfg.brightness <= {wr_bright_hi, wr_data};
            end
            default: begin
            end
         endcase
      end
   end
   // duty measurement: high samples over a fixed window of samples
   always_ff @(posedge clock) begin
      if (rst_all) begin
         period_cnt <= 12'h000;
         high_cnt <= 12'h000;
         pwm_code <= 11'h000;
      end else if (period_cnt == 12'(PWM_PERIOD - 1)) begin
         period_cnt <= 12'h000;
         high_cnt <= 12'h000;
         // scale to 11 bits; a full-high window reads as full scale
         pwm_code <= 11'((({11'h000, high_cnt} + 23'(pwm_lvl)) * 23'h7FF)
                         / 23'(PWM_PERIOD));
      end else begin
         period_cnt <= period_cnt + 12'h001;
         high_cnt <= high_cnt + 12'(pwm_lvl);
      end
   end
   // source selection; product keeps the upper 11 bits, plus one when bit 10 is set and they are nonzero
   always_comb begin
      product = 22'(cfg.brightness) * 22'(pwm_code);
      unique case (cfg.mode)
         blm_pkg::BLM_SRC_I2C: target = cfg.brightness;
         blm_pkg::BLM_SRC_PWM: target = pwm_code;
         blm_pkg::BLM_SRC_PROD_A,
         blm_pkg::BLM_SRC_PROD_B: target = product[21:11]
            + 11'(product[10] & |product[21:11]);
      endcase
   end
   // ramp one step per cycle toward the selected code
   always_ff @(posedge clock) begin
      if (rst_all) begin
         ramp <= 11'h000;
      end else if (ramp < target) begin
         ramp <= ramp + `BLM_RAMP_STEP;
      end else if (ramp > target) begin
         ramp <= ramp - `BLM_RAMP_STEP;
      end
   end
   // current only with pin, chip enable, a string and nonzero code
   always_comb begin
      next_on = en_lvl && cfg.chip_en && (|cfg.string_en) && (ramp != 11'h000);
      if (!en_lvl || !cfg.chip_en) begin
         next_state = blm_pkg::BLM_ST_SHUTDOWN;
      end else if (!next_on) begin
         next_state = blm_pkg::BLM_ST_STANDBY;
      end else begin
         next_state = blm_pkg::BLM_ST_ACTIVE;
      end
   end
   // drive outputs registered; zero code commands zero current in both maps
   always_ff @(posedge clock) begin
      if (srst) begin
         drive <= '0;
         state <= blm_pkg::BLM_ST_SHUTDOWN;
      end else begin
         drive.current_on <= next_on;
         drive.sink_on <= next_on ? cfg.string_en : 3'h0;
         drive.exp_map <= cfg.exp_map;
         drive.code <= next_on ? ramp : 11'h000;
         state <= next_state;
      end
   end
endmodule : blm_control

// ### tb/blm_control_assertions.sv
// port checker of the backlight enable and mode control
`timescale 1ns/1ps
module blm_control_assertions (
   input wire logic clock,
   input wire logic srst,
   input wire logic hardware_master_enable_pin,
   input wire logic pwm_in,
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [2:0] wr_bright_hi,
   input blm_pkg::blm_cfg_t cfg,
   input blm_pkg::blm_drive_t drive,
   input blm_pkg::blm_state_t state
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   // pin must be high long enough to pass its synchroniser before writes count
   chip_off_dark_a: assert property ((!cfg.chip_en) [*3] |-> !drive.current_on)
      else $error("current on with chip enable clear");
   no_string_dark_a: assert property ((cfg.string_en == 3'h0) [*3] |-> !drive.current_on)
      else $error("current on with no string enabled");
   zero_code_dark_a: assert property (drive.current_on |-> drive.code != 11'h000)
      else $error("current on with zero code");
   pin_low_cfg_a: assert property (!hardware_master_enable_pin [*8] |-> cfg == 18'h3D000)
      else $error("configuration not at defaults while pin low");
   pin_low_state_a: assert property (!hardware_master_enable_pin [*8] |-> state == blm_pkg::BLM_ST_SHUTDOWN && !drive.current_on)
      else $error("not shut down while pin low");
   enable_write_a: assert property ((hardware_master_enable_pin [*8] ##0 wr_en && wr_addr == 8'h10) |=> cfg.chip_en == $past(wr_data[0]) && cfg.string_en == $past(wr_data[3:1]))
      else $error("enable write not taken");
   map_write_a: assert property ((hardware_master_enable_pin [*8] ##0 wr_en && wr_addr == 8'h11) |=> cfg.exp_map == $past(wr_data[7]))
      else $error("mapping write not taken");
   mode_write_a: assert property ((hardware_master_enable_pin [*8] ##0 wr_en && wr_addr == 8'h19) |=> cfg.mode == $past(wr_data[6:5]) && cfg.brightness == $past({wr_bright_hi, wr_data}))
      else $error("mode or brightness write not taken");
endmodule : blm_control_assertions
bind blm_control blm_control_assertions blm_control_assertions_inst (.clock(clock), .srst(srst),
   .hardware_master_enable_pin(hardware_master_enable_pin), .pwm_in(pwm_in), .wr_en(wr_en),
   .wr_addr(wr_addr), .wr_data(wr_data), .wr_bright_hi(wr_bright_hi), .cfg(cfg),
   .drive(drive), .state(state));

// ### tb/blm_pwm_src.sv
// pwm brightness source with a programmable duty
`timescale 1ns/1ps
module blm_pwm_src #(
   parameter int PERIOD = 16
) (
   input wire logic clock,
   input wire logic [4:0] duty,
   output logic pwm = 1'b0
);
   logic [4:0] cnt = 5'h00;
   // duty equal to the period holds the line high for good
   always_ff @(posedge clock) begin
      cnt <= (cnt == 5'(PERIOD - 1)) ? 5'h00 : cnt + 5'h01;
      pwm <= (cnt < duty);
   end
endmodule : blm_pwm_src

// ### tb/tb.sv
// self-checking bench of the backlight enable and mode control
`timescale 1ns/1ps
module tb;
   logic clock = 1'b0, srst = 1'b1, pin = 1'b1, wr_en = 1'b0, pwm;
   logic [7:0] wr_addr = 8'h00, wr_data = 8'h00;
   logic [2:0] wr_hi = 3'h0;
   logic [4:0] duty = 5'h10;
   int err_total = 0, compares = 0;
   blm_pkg::blm_cfg_t cfg;
   blm_pkg::blm_drive_t drive;
   blm_pkg::blm_state_t state;
   always #2.5 clock = ~clock;
   blm_pwm_src #(.PERIOD(16)) blm_pwm_src_inst (.clock(clock), .duty(duty), .pwm(pwm));
   // short duty window keeps the run brief
   blm_control #(.PWM_PERIOD(16)) blm_control_inst (.clock(clock), .srst(srst),
      .hardware_master_enable_pin(pin), .pwm_in(pwm), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data), .wr_bright_hi(wr_hi), .cfg(cfg), .drive(drive), .state(state));
   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   // one-cycle write strobe, inputs move 1 ns after the edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [2:0] h);
      tick(1);
      {wr_en, wr_addr, wr_data, wr_hi} = {1'b1, a, d, h};
      tick(1);
      wr_en = 1'b0;
   endtask : wr
   // ramp moves one step a cycle, so the bound covers a full sweep
   task automatic wait_code(input logic [10:0] exp);
      repeat (5000) if (drive.code !== exp) tick(1);
      chk(drive.code, exp);
      if (drive.code !== exp) report_and_stop();
      tick(2);
   endtask : wait_code
   task automatic t_pwm;
      wait_code(11'h7FF);
      chk(drive.current_on, 1'b1);
      chk(drive.exp_map, 1'b0);
      chk(state, blm_pkg::BLM_ST_ACTIVE);
      duty = 5'h00;
      wait_code(11'h000);
      chk(state, blm_pkg::BLM_ST_STANDBY);
      $display("pwm test done");
   endtask : t_pwm
   task automatic t_i2c;
      wr(8'h10, 8'h03, 3'h0);
      wr(8'h19, 8'h1F, 3'h0);
      tick(8);
      chk(drive.code < 11'h1F, 1'b1);
      wait_code(11'h01F);
      chk({drive.current_on, drive.sink_on}, 4'h9);
      wr(8'h11, 8'h80, 3'h0);
      tick(4);
      chk(drive.exp_map, 1'b1);
      wr(8'h19, 8'hDF, 3'h7);
      tick(40);
      chk(drive.code, 11'h000);
      duty = 5'h10;
      tick(100);
      chk(drive.current_on, 1'b1);
      // mode 11 is the second product code; full-scale i2c times full-scale duty
      wr(8'h19, 8'hFF, 3'h7);
      wait_code(11'h7FE);
      chk(cfg.mode, blm_pkg::BLM_SRC_PROD_B);
      wr(8'h10, 8'h0E, 3'h0);
      tick(8);
      chk(drive.current_on, 1'b0);
      wr(8'h10, 8'h01, 3'h0);
      tick(8);
      chk(drive.current_on, 1'b0);
      $display("i2c test done");
   endtask : t_i2c
   task automatic t_pin;
      pin = 1'b0;
      tick(10);
      chk(cfg, 18'h3D000);
      chk(state, blm_pkg::BLM_ST_SHUTDOWN);
      $display("pin test done");
   endtask : t_pin
   initial begin
      tick(20);
      srst = 1'b0;
      t_pwm();
      t_i2c();
      t_pin();
      report_and_stop();
   end
endmodule : tb
